//--- design/dlc_pkg.sv
// Package of offsets, field layouts, reset values and timing for the config bank.
package dlc_pkg;
    localparam logic [7:0] ADDR_RUN = 8'h01;
    localparam logic [7:0] ADDR_GEN = 8'h02;
    localparam logic [7:0] ADDR_CLUSTER = 8'h03;
    localparam logic [7:0] ADDR_TIMEOUT = 8'h04;
    localparam int SLEW_LSB = 4;
    localparam int DIV_LSB = 2;
    localparam int CLKSEL_LSB = 0;
    localparam int WD_EN_BIT = 12;
    localparam logic [12:0] GEN_RESET = 13'h0000;
    localparam logic [12:0] CLUSTER_RESET = 13'h0001;
    localparam logic [12:0] TIMEOUT_RESET = 13'h0000;
    localparam logic [15:0] DIV_BASE = 16'h2000;
    // Slew times in nanoseconds per code, slowest first.
    localparam int SLEW_NS_0 = 10000;
    localparam int SLEW_NS_7 = 500;
    localparam int CLK_PERIOD_NS = 5;
    typedef enum logic [1:0] {
        DLC_SRC_INT_OFF = 2'h0,
        DLC_SRC_INT_OUT = 2'h1,
        DLC_SRC_EXT_LOW = 2'h2,
        DLC_SRC_EXT_HIGH = 2'h3
    } dlc_src_t;
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [12:0] data;
    } dlc_req_t;
    typedef struct packed {
        logic cluster_call;
        logic [5:0] cluster_identifier;
    } dlc_call_t;
endpackage : dlc_pkg

//--- design/dlc_regs.sv
// Configuration register bank with dimming divider and link watchdog.
`timescale 1ns/1ps
module dlc_regs (
    input wire logic clk_sys_in,
    input wire logic resetn_in,
    input wire dlc_pkg::dlc_req_t req_in,
    input wire dlc_pkg::dlc_call_t call_in,
    input wire logic link_timeout_in,
    input wire logic osc_tick_in,
    input wire logic ext_clk_in,
    input wire logic [5:0] prog_switch_in,
    output logic [12:0] rdata_out,
    output logic call_accept_out,
    output logic pwm_tick_out,
    output logic clk_pin_out,
    output logic clk_pin_oe_out,
    output logic [5:0] switch_closed_out,
    output logic [15:0] slew_cycles_out,
    output logic fault_n_out
);
    import dlc_pkg::*;

    logic [12:0] general_dimming_config;
    logic [12:0] cluster_id_config;
    logic [12:0] link_timeout_config;
    logic switching_run;
    logic [1:0] ext_sync;
    logic ext_prev;
    logic [15:0] div_cnt;
    logic wd_tripped;

    // Slew time per code in ns; converted to system cycles below.
    function automatic logic [15:0] slew_ns(input logic [2:0] code);
        unique case (code)
            3'h0: slew_ns = 16'(SLEW_NS_0);
            3'h1: slew_ns = 16'h1A0E;
            3'h2: slew_ns = 16'h1388;
            3'h3: slew_ns = 16'h0CE4;
            3'h4: slew_ns = 16'h09C4;
            3'h5: slew_ns = 16'h05DC;
            3'h6: slew_ns = 16'h03E8;
            3'h7: slew_ns = 16'(SLEW_NS_7);
        endcase
    endfunction : slew_ns

    // Decode of fields and write strobes.
    wire [2:0] gate_slew_sel = general_dimming_config[SLEW_LSB +: 3];
    wire [1:0] div_sel = general_dimming_config[DIV_LSB +: 2];
    wire [1:0] src_sel = general_dimming_config[CLKSEL_LSB +: 2];
    wire [5:0] cluster_identifier = cluster_id_config[5:0];
    wire [5:0] timeout_switch_pattern = link_timeout_config[5:0];
    wire wd_enable = link_timeout_config[WD_EN_BIT];
    wire wr_run = req_in.wr && req_in.addr == ADDR_RUN;
    wire wr_gen = req_in.wr && req_in.addr == ADDR_GEN;
    wire wr_cluster = req_in.wr && req_in.addr == ADDR_CLUSTER;
    wire wr_timeout = req_in.wr && req_in.addr == ADDR_TIMEOUT;
    wire src_ext = src_sel[1];
    wire ext_rise = ext_sync[1] && !ext_prev;
    wire base_tick = src_ext ? ext_rise : osc_tick_in;
    // Terminal count is one less than 8192 shifted left by the divider code.
    wire [15:0] div_last = 16'((32'(DIV_BASE) << div_sel) - 1);
    wire div_wrap = base_tick && div_cnt == div_last;
    wire [15:0] next_slew_cycles = 16'(
        (32'(slew_ns(gate_slew_sel)) + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    wire [12:0] next_rdata =
        req_in.addr == ADDR_RUN ? {12'h000, switching_run} :
        req_in.addr == ADDR_GEN ? general_dimming_config :
        req_in.addr == ADDR_CLUSTER ? cluster_id_config :
        req_in.addr == ADDR_TIMEOUT ? link_timeout_config : 13'h0000;
    wire trip_now = wd_enable && (link_timeout_in || wd_tripped);
    wire [5:0] next_switch = trip_now ? timeout_switch_pattern :
        (switching_run ? prog_switch_in : 6'h3F);

    // Register writes; slew spacing is left to the host.
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            general_dimming_config <= GEN_RESET;
            cluster_id_config <= CLUSTER_RESET;
            link_timeout_config <= TIMEOUT_RESET;
            switching_run <= 1'b0;
        end else begin
            if (wr_gen) general_dimming_config <= req_in.data;
            if (wr_cluster) cluster_id_config <= {7'h00, req_in.data[5:0]};
            if (wr_timeout) link_timeout_config <=
                {req_in.data[12], 6'h00, req_in.data[5:0]};
            if (wr_run) switching_run <= req_in.data[0];
        end
    end

    // External clock pin is synchronised before edge detection.
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            ext_sync <= 2'b00;
            ext_prev <= 1'b0;
        end else begin
            ext_sync <= {ext_sync[0], ext_clk_in};
            ext_prev <= ext_sync[1];
        end
    end

    // Dimming divider; held at zero while not running.
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            div_cnt <= 16'h0000;
            pwm_tick_out <= 1'b0;
        end else begin
            pwm_tick_out <= switching_run && div_wrap;
            if (!switching_run || div_wrap) div_cnt <= 16'h0000;
            else if (base_tick) div_cnt <= div_cnt + 16'h0001;
        end
    end

    // Watchdog latch stays tripped until the watchdog is disabled.
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            wd_tripped <= 1'b0;
            fault_n_out <= 1'b1;
            switch_closed_out <= 6'h3F;
        end else begin
            wd_tripped <= trip_now;
            fault_n_out <= !trip_now;
            switch_closed_out <= next_switch;
        end
    end

    // Outputs: read data, cluster match, clock pin, slew count.
    always_ff @(posedge clk_sys_in or negedge resetn_in) begin
        if (!resetn_in) begin
            rdata_out <= 13'h0000;
            call_accept_out <= 1'b0;
            clk_pin_out <= 1'b0;
            clk_pin_oe_out <= 1'b0;
            slew_cycles_out <= 16'h0000;
        end else begin
            rdata_out <= next_rdata;
            call_accept_out <= call_in.cluster_call &&
                call_in.cluster_identifier == cluster_identifier;
            clk_pin_out <= osc_tick_in;
            clk_pin_oe_out <= src_sel == DLC_SRC_INT_OUT;
            slew_cycles_out <= next_slew_cycles;
        end
    end

    // Checks.
    property p_accept;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        call_in.cluster_call && call_in.cluster_identifier ==
            cluster_id_config[5:0] |=> call_accept_out;
    endproperty
    a_accept: assert property (p_accept) else $error("call lost");
    property p_reject;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        call_in.cluster_identifier != cluster_id_config[5:0]
            |=> !call_accept_out;
    endproperty
    a_reject: assert property (p_reject) else $error("bad call");
    property p_fault;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        wd_enable && link_timeout_in |=> !fault_n_out &&
            switch_closed_out == $past(timeout_switch_pattern);
    endproperty
    a_fault: assert property (p_fault) else $error("no fault");
    property p_wd_off;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        !wd_enable |=> fault_n_out;
    endproperty
    a_wd_off: assert property (p_wd_off) else $error("wd off");
    property p_idle;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        !switching_run && !trip_now |=> switch_closed_out == 6'h3F
            && div_cnt == 16'h0000;
    endproperty
    a_idle: assert property (p_idle) else $error("idle bad");
    property p_pin;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        src_sel != DLC_SRC_INT_OUT |=> !clk_pin_oe_out;
    endproperty
    a_pin: assert property (p_pin) else $error("pin driven");
    property p_div;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        base_tick && switching_run |=> div_cnt <= div_last;
    endproperty
    a_div: assert property (p_div) else $error("div range");
    property p_slew;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        gate_slew_sel == 3'h7 ##1 gate_slew_sel == 3'h7
            |-> slew_cycles_out == 16'h0064;
    endproperty
    a_slew: assert property (p_slew) else $error("slew");
    property p_ext;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        !src_ext && !osc_tick_in |-> !base_tick;
    endproperty
    a_ext: assert property (p_ext) else $error("src");
    c_accept: cover property (@(posedge clk_sys_in) call_accept_out);
    c_fault: cover property (@(posedge clk_sys_in) !fault_n_out);
    // Running switches follow the programmed pattern one cycle later.
    property p_run_sw;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        switching_run && !trip_now |=>
            switch_closed_out == $past(prog_switch_in);
    endproperty
    a_run_sw: assert property (p_run_sw) else $error("run sw");
    // Source code one must turn the clock pin into an output.
    property p_pin_on;
        @(posedge clk_sys_in) disable iff (!resetn_in)
        src_sel == DLC_SRC_INT_OUT |=> clk_pin_oe_out;
    endproperty
    a_pin_on: assert property (p_pin_on) else $error("pin off");
    c_tick: cover property (@(posedge clk_sys_in) pwm_tick_out);
    // External edges only count while the external source is chosen.
    c_ext: cover property (@(posedge clk_sys_in) src_ext && base_tick);
endmodule : dlc_regs

//--- tb/dlc_host.sv
// Host model that drives register requests and cluster calls.
`timescale 1ns/1ps
module dlc_host (
    input wire logic clk_sys_in,
    output dlc_pkg::dlc_req_t req_out,
    output dlc_pkg::dlc_call_t call_out,
    output logic rd_v_out
);
    import dlc_pkg::*;
    // Bus idles from time zero.
    initial {req_out, call_out, rd_v_out} = '0;
    // Each request starts after an edge and lasts one cycle.
    // The slew spacing of one dimming period is not kept here.
    task automatic wr(input logic [7:0] a, input logic [12:0] d);
        @(posedge clk_sys_in) #1 req_out = '{1'b1, a, d};
        @(posedge clk_sys_in) #1 req_out.wr = 1'b0;
    endtask : wr
    // The address stays put afterwards, since read data follows it.
    task automatic rd(input logic [7:0] a);
        @(posedge clk_sys_in) #1 req_out.addr = a;
        rd_v_out = 1'b1;
        @(posedge clk_sys_in) #1 rd_v_out = 1'b0;
    endtask : rd
    task automatic call(input logic [5:0] id);
        @(posedge clk_sys_in) #1 call_out = '{1'b1, id};
        @(posedge clk_sys_in) #1 call_out.cluster_call = 1'b0;
    endtask : call
endmodule : dlc_host

//--- tb/dimming_link_config_regs_tb.sv
// Self-checking bench for the dimming and link config bank.
`timescale 1ns/1ps
module dimming_link_config_regs_tb;
    import dlc_pkg::*;
    logic clk_sys_in = 0, resetn_in = 0, link_timeout_in = 0;
    logic osc_tick_in = 1, ext_clk_in = 0, rd_v, pr = 0, pc = 0;
    logic call_accept_out, pwm_tick_out, clk_pin_out, clk_pin_oe_out;
    logic fault_n_out, qa[$];
    logic [5:0] prog_switch_in = '0, switch_closed_out, id, pat;
    logic [12:0] rdata_out, g, qr[$];
    logic [15:0] slew_cycles_out;
    dlc_req_t req_in;
    dlc_call_t call_in;
    int n_fail = 0, checks = 0, cyc = 0, gap = 0, per = 0;
    int sl_ns[8] = '{10000, 6670, 5000, 3300, 2500, 1500, 1000, 500};
    dlc_regs u_dlc_regs (.*);
    dlc_host u_dlc_host (.clk_sys_in(clk_sys_in), .req_out(req_in),
        .call_out(call_in), .rd_v_out(rd_v));
    // Free-running clock; the external pin toggles every cycle.
    initial forever #2.5 clk_sys_in = ~clk_sys_in;
    always @(posedge clk_sys_in) #1 ext_clk_in = ~ext_clk_in;
    // Note strobes and time the gap between dimming ticks.
    always @(posedge clk_sys_in) begin
        pr <= rd_v;
        pc <= call_in.cluster_call;
        gap <= pwm_tick_out ? 1 : gap + 1;
        if (pwm_tick_out) per <= gap;
        cyc <= cyc + 1;
    end
    // Compare half a cycle later, so the edge's updates have landed.
    always @(negedge clk_sys_in) begin
        if (pr) chk("rdata", qr.pop_front(), rdata_out);
        if (pc) chk("accept", qa.pop_front(), call_accept_out);
        if (cyc == 100000) begin
            n_fail++;
            results();
        end
    end
    task automatic chk(input string n, input logic [15:0] e,
        input logic [15:0] s);
        checks++;
        if (s !== e) begin
            n_fail++;
            $display("MISMATCH %s exp=%h got=%h", n, e, s);
        end
    endtask : chk
    task automatic results;
        $display("checks=%0d n_fail=%0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : results
    task automatic rd(input logic [7:0] a, input logic [12:0] e);
        qr.push_back(e);
        u_dlc_host.rd(a);
    endtask : rd
    task automatic call(input logic [5:0] i, input logic e);
        qa.push_back(e);
        u_dlc_host.call(i);
    endtask : call
    // Program the watchdog, then raise one timeout pulse.
    task automatic tmo(input logic [12:0] cfg);
        u_dlc_host.wr(ADDR_TIMEOUT, cfg);
        link_timeout_in = 1'b1;
        @(posedge clk_sys_in) #1 link_timeout_in = 1'b0;
        @(posedge clk_sys_in) #1;
    endtask : tmo
    // Restart the divider from zero, then time the second tick.
    task automatic period(input logic [12:0] c, input logic [15:0] p);
        u_dlc_host.wr(ADDR_RUN, 13'h0000);
        u_dlc_host.wr(ADDR_GEN, c);
        u_dlc_host.wr(ADDR_RUN, 13'h0001);
        repeat (2) @(posedge pwm_tick_out);
        @(posedge clk_sys_in) #1;
        chk("period", p, per[15:0]);
    endtask : period
    // Reset, then walk through the bank's behaviour.
    initial begin
        void'($urandom(69));
        prog_switch_in = 6'($urandom);
        repeat (4) @(posedge clk_sys_in);
        #1 resetn_in = 1'b1;
        chk("sw_idle", 6'h3F, switch_closed_out);
        rd(ADDR_RUN, 13'h0000);
        rd(ADDR_GEN, GEN_RESET);
        rd(ADDR_CLUSTER, CLUSTER_RESET);
        rd(ADDR_TIMEOUT, TIMEOUT_RESET);
        rd(8'h0F, 13'h0000);
        call(6'h01, 1'b1);
        id = 6'($urandom);
        u_dlc_host.wr(ADDR_CLUSTER, {7'h7F, id});
        rd(ADDR_CLUSTER, {7'h00, id});
        call(id, 1'b1);
        call(id ^ 6'h01, 1'b0);
        // Slew is set while run is clear, so no dimming period is cut.
        for (int i = 0; i < 8; i++) begin
            g = 13'(i * 16 + i % 4);
            u_dlc_host.wr(ADDR_GEN, g);
            @(posedge clk_sys_in) #1;
            chk("slew", 16'((sl_ns[i] + 4) / 5), slew_cycles_out);
            chk("pin_oe", {15'h0000, i % 4 == 1}, clk_pin_oe_out);
            rd(ADDR_GEN, g);
        end
        u_dlc_host.wr(ADDR_RUN, 13'h0001);
        repeat (2) @(posedge clk_sys_in);
        #1 chk("sw_run", prog_switch_in, switch_closed_out);
        chk("clk_pin", 16'h0001, clk_pin_out);
        pat = 6'($urandom);
        tmo({7'h00, pat});
        chk("fault_off", 1'b1, fault_n_out);
        tmo({7'h40, pat});
        chk("fault_on", 1'b0, fault_n_out);
        chk("sw_pat", pat, switch_closed_out);
        rd(ADDR_TIMEOUT, {7'h40, pat});
        tmo(13'h0000);
        chk("fault_clr", 1'b1, fault_n_out);
        period(13'h0000, 16'h2000);
        period(13'h0004, 16'h4000);
        period(13'h0002, 16'h4000);
        results();
    end
endmodule : dimming_link_config_regs_tb
